// *** logic/stc_timer.v ***
// sixteen bit timer counter with apb register access and overflow interrupt
//
// Summary of operation
// - count only while run_enable is set
// - wide access makes 16-bit transfers atomic
// - osc_clock_status bit 6 reads device clock source
// - prescale codes 11/10/01 divide by 8/4/2
// - osc_enable powers the module oscillator
// - sync_bypass selects unsynchronised external counting
// - internal source counts each instruction cycle
// - external source counts pin or oscillator edges
// - timer, sync counter, async counter modes
// - enabled module forces oscillator pins input
// - count readable and writable as two bytes
// - wrap ffff to 0000 sets overflow flag
// - wide low read latches high byte
// - wide high write buffers; low write loads
// - low write clears prescaler, high does not
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"

module stc_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        ext_clock_pin,
  input  wire        osc_in_pin,
  input  wire        sys_clk_from_osc,
  input  wire [1:0]  port_c_direction,
  output wire [1:0]  port_c_oe,
  output wire        osc_power_en,
  output wire        irq
);

  // ==========================================================
  // registers
  reg  [7:0]  ctrl_r;
  reg  [15:0] count_r;
  reg  [7:0]  high_buf_r;
  reg         overflow_flag_r;
  reg         mask_r;
  reg  [31:0] rd_nxt;
  reg         rd_hit;
  reg  [7:0]  snap_high_r;   // live high byte at read setup
  reg         snap_flag_r;   // flag value returned by a status read
  reg  [1:0]  inst_cnt_r;
  reg         sync_pend_r;

  wire        run_enable          = ctrl_r[`STC_CTRL_RUN];
  wire        clock_source_select = ctrl_r[`STC_CTRL_CS];
  wire        sync_bypass         = ctrl_r[`STC_CTRL_SYNC_BYP];
  wire        osc_enable          = ctrl_r[`STC_CTRL_OSC_EN];
  wire [1:0]  input_prescale_select = ctrl_r[`STC_CTRL_PS_HI:`STC_CTRL_PS_LO];
  wire        wide_access_enable  = ctrl_r[`STC_CTRL_WIDE];

  // ==========================================================
  // apb decode: zero wait states, error on unmapped offsets
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr      = access & pwrite;
  wire rd      = access & ~pwrite;
  wire sel_ctl = (paddr == `STC_OFS_CTRL);
  wire sel_lo  = (paddr == `STC_OFS_COUNT_LOW);
  wire sel_hi  = (paddr == `STC_OFS_COUNT_HIGH);
  wire sel_st  = (paddr == `STC_OFS_IRQ_STATUS);
  wire sel_msk = (paddr == `STC_OFS_IRQ_MASK);
  wire mapped  = sel_ctl | sel_lo | sel_hi | sel_st | sel_msk;

  // every register answers at once, so no wait state is ever inserted;
  // an unmapped offset still completes, with an error and zero data
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  wire wr_ctl = wr & sel_ctl;
  wire wr_lo  = wr & sel_lo;
  wire wr_hi  = wr & sel_hi;
  wire wr_msk = wr & sel_msk;
  wire rd_lo  = rd & sel_lo;
  wire rd_st  = rd & sel_st;

  // ==========================================================
  // pin inputs: all pass two flops before use
  wire ext_rise;
  wire osc_rise;
  wire osc_stat_sync;

  stc_edge_sync u_ext_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (ext_clock_pin),
    .level_out (),
    .rise_out  (ext_rise)
  );

  stc_edge_sync u_osc_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (osc_in_pin),
    .level_out (),
    .rise_out  (osc_rise)
  );

  stc_edge_sync u_stat_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (sys_clk_from_osc),
    .level_out (osc_stat_sync),
    .rise_out  ()
  );

  // ==========================================================
  // oscillator power and pin direction override
  assign osc_power_en = osc_enable;
  // oe high drives the pin; a set direction bit means input.
  // while counting the module never drives its oscillator pins, so a
  // crystal or an external source cannot fight the port output
  assign port_c_oe    = run_enable ? 2'h0 : ~port_c_direction;

  // ==========================================================
  // instruction cycle strobe: one core clock in four
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inst_cnt_r <= 2'h0;
    else
      inst_cnt_r <= inst_cnt_r + 2'h1;
  end

  // the divider runs free from reset, so the first internal increment
  // after run_enable rises may come anywhere in the next four clocks
  wire inst_tick = (inst_cnt_r == `STC_INST_DIV);

  // ==========================================================
  // source selection; the oscillator replaces the pin when enabled
  wire ext_edge = osc_enable ? osc_rise : ext_rise;

  // synchronous counter mode holds an edge until the next
  // instruction cycle; asynchronous mode counts it at once.
  // trade-off: holding only one pending edge means pin edges closer
  // than an instruction cycle are merged in synchronous mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_pend_r <= 1'b0;
    else if (inst_tick)
      sync_pend_r <= 1'b0;
    else if (ext_edge)
      sync_pend_r <= 1'b1;
  end

  reg src_event;

  // mode select from clock_source_select and sync_bypass
  always @*
  begin
    if (!clock_source_select)
      src_event = inst_tick;
    else if (sync_bypass)
      src_event = ext_edge;
    else
      src_event = inst_tick & (sync_pend_r | ext_edge);
  end

  // ==========================================================
  // prescaler; a low byte write restarts it.
  // limitation: lowering the ratio while counting can leave the count
  // past the new terminal value; it then wraps once before dividing
  wire tick;

  stc_prescaler u_pre
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (wr_lo),
    .ratio_sel (input_prescale_select),
    .event_in  (src_event & run_enable),
    .event_out (tick)
  );

  wire incr = tick & run_enable;
  wire wrap = incr & (count_r == `STC_COUNT_MAX);

  // ==========================================================
  // counter; a software write wins over a same-cycle increment,
  // so the value written is exactly the value counting resumes from
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= `STC_COUNT_RESET;
    else if (wr_lo && wide_access_enable)
      count_r <= {high_buf_r, pwdata[7:0]};
    else if (wr_lo)
      count_r <= {count_r[15:8], pwdata[7:0]};
    else if (wr_hi && !wide_access_enable)
      count_r <= {pwdata[7:0], count_r[7:0]};
    else if (incr)
      count_r <= count_r + 16'h0001;
  end

  // ==========================================================
  // high byte buffer used only with wide access.
  // hazard: one buffer serves both directions, so a low read between a
  // high write and a low write replaces the value software wrote
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_buf_r <= 8'h00;
    else if (wr_hi && wide_access_enable)
      high_buf_r <= pwdata[7:0];
    else if (rd_lo && wide_access_enable)
      high_buf_r <= snap_high_r;
  end

  // ==========================================================
  // control and mask; status bit 6 is not writable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `STC_CTRL_RESET;
      mask_r <= `STC_MASK_RESET;
    end
    else
    begin
      if (wr_ctl)
        ctrl_r <= pwdata[7:0] & 8'hbf;
      if (wr_msk)
        mask_r <= pwdata[0];
    end
  end

  // ==========================================================
  // overflow flag: set wins over the clear by a status read;
  // only a flag value that was returned is cleared, so software
  // never loses a wrap that lands between setup and access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_flag_r <= 1'b0;
    else if (wrap)
      overflow_flag_r <= 1'b1;
    else if (rd_st && snap_flag_r)
      overflow_flag_r <= 1'b0;
  end

  assign irq = overflow_flag_r & mask_r;

  // ==========================================================
  // read mux evaluated in the setup phase; unmapped offsets and the
  // unused upper bits of every register read as zero
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `STC_OFS_CTRL:
        rd_nxt[7:0] = {ctrl_r[7], osc_stat_sync, ctrl_r[5:0]};
      `STC_OFS_COUNT_LOW:
        rd_nxt[7:0] = count_r[7:0];
      `STC_OFS_COUNT_HIGH:
        rd_nxt[7:0] = wide_access_enable ? high_buf_r : count_r[15:8];
      `STC_OFS_IRQ_STATUS:
        rd_nxt[0] = overflow_flag_r;
      `STC_OFS_IRQ_MASK:
        rd_nxt[0] = mask_r;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // read data and snapshots are taken at the setup edge so the
  // low byte and the latched high byte come from the same count
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata      <= 32'h0000_0000;
      snap_high_r <= 8'h00;
      snap_flag_r <= 1'b0;
    end
    else if (setup && !pwrite)
    begin
      prdata      <= rd_hit ? rd_nxt : 32'h0000_0000;
      snap_high_r <= count_r[15:8];
      snap_flag_r <= overflow_flag_r;
    end
  end

endmodule
`default_nettype wire

// *** logic/stc_consts.vh ***
// constants for the sixteen bit timer counter: offsets, fields, reset values, counts
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH

// ==========================================================
// register byte offsets on the apb bus
`define STC_OFS_CTRL        12'h000
`define STC_OFS_COUNT_LOW   12'h004
`define STC_OFS_COUNT_HIGH  12'h008
`define STC_OFS_IRQ_STATUS  12'h00c
`define STC_OFS_IRQ_MASK    12'h010

// ==========================================================
// counter_control field positions
`define STC_CTRL_RUN        0
`define STC_CTRL_CS         1
`define STC_CTRL_SYNC_BYP   2
`define STC_CTRL_OSC_EN     3
`define STC_CTRL_PS_LO      4
`define STC_CTRL_PS_HI      5
`define STC_CTRL_OSC_STAT   6
`define STC_CTRL_WIDE       7

// ==========================================================
// prescale codes
`define STC_PS_DIV1         2'h0
`define STC_PS_DIV2         2'h1
`define STC_PS_DIV4         2'h2
`define STC_PS_DIV8         2'h3

// ==========================================================
// reset values and maximum count
`define STC_CTRL_RESET      8'h00
`define STC_COUNT_RESET     16'h0000
`define STC_MASK_RESET      1'h0
`define STC_COUNT_MAX       16'hffff

// ==========================================================
// timing: instruction cycle is four core clocks
`define STC_INST_DIV        2'h3

`endif

// *** logic/stc_edge_sync.v ***
// two flop synchroniser with rising edge detect for one pin input
`timescale 1ns/1ps
`default_nettype none

module stc_edge_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire pin_in,
  output wire level_out,
  output wire rise_out
);

  reg meta_r;
  reg sync_r;
  reg last_r;

  // ==========================================================
  // synchroniser; only sync_r reads meta_r
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out  = sync_r & ~last_r;  // one cycle pulse per rising edge

endmodule
`default_nettype wire

// *** logic/stc_prescaler.v ***
// 1/2/4/8 event prescaler with synchronous clear
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"

module stc_prescaler
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clear,
  input  wire [1:0] ratio_sel,
  input  wire       event_in,
  output reg        event_out
);

  reg [2:0] pre_cnt_r;
  reg [2:0] last_val;

  // ==========================================================
  // terminal value per ratio code
  always @*
  begin
    case (ratio_sel)
      `STC_PS_DIV2: last_val = 3'h1;
      `STC_PS_DIV4: last_val = 3'h3;
      `STC_PS_DIV8: last_val = 3'h7;
      default:      last_val = 3'h0;  // undivided
    endcase
    event_out = event_in & (pre_cnt_r == last_val);
  end

  // ==========================================================
  // count events; a clear wins over a concurrent event
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_cnt_r <= 3'h0;
    else if (clear)
      pre_cnt_r <= 3'h0;
    else if (event_in)
      pre_cnt_r <= (pre_cnt_r == last_val) ? 3'h0 : pre_cnt_r + 3'h1;
  end

endmodule
`default_nettype wire

// *** testbench/stc_clock_model.sv ***
// far-side clock source model: external count pin and module crystal output
`timescale 1ns/1ps
`default_nettype none
module stc_clock_model
(
  input  wire logic pclk,
  output wire logic ext_clock_pin,
  output wire logic osc_in_pin
);
  // ==========================================================
  // pin drive
  logic [1:0] pins_r = 2'h0;
  // both pins rest low between bursts, so no stray edge reaches the counter
  assign ext_clock_pin = pins_r[0];
  assign osc_in_pin    = pins_r[1];
  // n periods on one pin; each level lasts half cycles, never below two
  task automatic burst(input int sel, input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge pclk);
      pins_r[sel] <= 1'b1;
      repeat (half) @(posedge pclk);
      pins_r[sel] <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/stc_timer_properties.sv ***
// port-level assertions for the timer counter
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module stc_timer_properties
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [1:0]  port_c_direction,
  input wire logic [1:0]  port_c_oe,
  input wire logic        osc_power_en,
  input wire logic        irq
);
  // ==========================================================
  // shadow of the writable control and mask bits
  logic [7:0] ctl_r;
  logic       msk_r;
  wire wr_acc = psel && penable && pwrite;
  wire rd_set = psel && !penable && !pwrite;
  wire unmap  = paddr > `STC_OFS_IRQ_MASK || paddr[1:0] != 2'h0;
  // follows bus writes only, so a stuck design register shows up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r <= 8'h00;
      msk_r <= 1'b0;
    end
    else if (wr_acc && paddr == `STC_OFS_CTRL)
      ctl_r <= pwdata[7:0];
    else if (wr_acc && paddr == `STC_OFS_IRQ_MASK)
      msk_r <= pwdata[0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // properties
  chk_ready_always: assert property (pready)
    else $error("pready low");
  chk_err_decode: assert property (pslverr == (psel && penable && unmap))
    else $error("pslverr decode wrong");
  chk_pins_input: assert property (port_c_oe == (ctl_r[0] ? 2'h0 : ~port_c_direction))
    else $error("oscillator pin enable wrong");
  chk_osc_power: assert property (osc_power_en == ctl_r[3])
    else $error("oscillator power wrong");
  chk_ctrl_readback: assert property (rd_set && paddr == `STC_OFS_CTRL |=>
    prdata[5:0] == ctl_r[5:0] && prdata[7] == ctl_r[7] && prdata[31:8] == 24'h0)
    else $error("control read back wrong");
  chk_unmap_zero: assert property (rd_set && unmap |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_data_hold: assert property (!rd_set |=> $stable(prdata))
    else $error("read data moved");
  chk_irq_masked: assert property (irq |-> msk_r)
    else $error("irq while masked");
  chk_irq_cause: assert property ($rose(irq) |->
    $past(ctl_r[0]) || $past(wr_acc && paddr == `STC_OFS_IRQ_MASK))
    else $error("irq rose without cause");
endmodule
`default_nettype wire

// *** testbench/stc_timer_test.sv ***
// self-checking bench for the sixteen bit timer counter
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module stc_timer_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        sys_clk_from_osc = 1'b0;
  logic [1:0]  port_c_direction = 2'h1;
  wire         pready, pslverr, osc_power_en, irq, ext_clock_pin, osc_in_pin;
  wire  [31:0] prdata;
  wire  [1:0]  port_c_oe;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          checks = 0;
  // 10 MHz core clock
  always #50 pclk = ~pclk;
  stc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .ext_clock_pin(ext_clock_pin), .osc_in_pin(osc_in_pin), .sys_clk_from_osc(sys_clk_from_osc),
    .port_c_direction(port_c_direction), .port_c_oe(port_c_oe), .osc_power_en(osc_power_en), .irq(irq));
  stc_clock_model src (.pclk(pclk), .ext_clock_pin(ext_clock_pin), .osc_in_pin(osc_in_pin));
  // ==========================================================
  // bus and compare helpers
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // the request stands until pready is seen; the watchdog bounds this wait
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rc("ctrl", `STC_OFS_CTRL, 32'h0);
    rc("mask", `STC_OFS_IRQ_MASK, 32'h0);
    chk("oe", {30'h0, ~port_c_direction}, {30'h0, port_c_oe});
    port_c_direction <= 2'h2;
    @(posedge pclk);
    chk("oe dir", 32'h1, {30'h0, port_c_oe});
  endtask
  task automatic t_bytes();
    bus(1'b1, `STC_OFS_COUNT_HIGH, 32'h12);
    bus(1'b1, `STC_OFS_COUNT_LOW, 32'h34);
    bus(1'b1, `STC_OFS_CTRL, 32'h40);
    repeat (20) @(posedge pclk);
    rc("low", `STC_OFS_COUNT_LOW, 32'h34);
    rc("high", `STC_OFS_COUNT_HIGH, 32'h12);
    rc("status bit", `STC_OFS_CTRL, 32'h0);
    sys_clk_from_osc <= 1'b1;
    repeat (4) @(posedge pclk);
    rc("status bit", `STC_OFS_CTRL, 32'h40);
    sys_clk_from_osc <= 1'b0;
  endtask
  task automatic t_prescale();
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, `STC_OFS_COUNT_LOW, 32'h0);
      bus(1'b1, `STC_OFS_CTRL, 32'(i * 16 + 1));
      // eight counts expected whatever the ratio; phase costs at most one
      repeat (32 << i) @(posedge pclk);
      chk("oe run", 32'h0, {30'h0, port_c_oe});
      bus(1'b1, `STC_OFS_CTRL, 32'h0);
      bus(1'b0, `STC_OFS_COUNT_LOW, 32'h0);
      chk("low err", 32'h0, {31'h0, err});
      chk("ratio", 32'h1, {31'h0, rd[7:0] >= 8'h07 && rd[7:0] <= 8'h09});
    end
  endtask
  task automatic t_wide();
    bus(1'b1, `STC_OFS_CTRL, 32'h80);
    bus(1'b0, `STC_OFS_COUNT_LOW, 32'h0);
    rc("latched high", `STC_OFS_COUNT_HIGH, 32'h12);
    // a low read refills the buffer, so the high write must follow it
    bus(1'b1, `STC_OFS_COUNT_HIGH, 32'hab);
    bus(1'b1, `STC_OFS_COUNT_LOW, 32'hcd);
    bus(1'b1, `STC_OFS_CTRL, 32'h0);
    rc("low", `STC_OFS_COUNT_LOW, 32'hcd);
    rc("high", `STC_OFS_COUNT_HIGH, 32'hab);
  endtask
  task automatic t_overflow();
    bus(1'b1, `STC_OFS_COUNT_HIGH, 32'hff);
    bus(1'b1, `STC_OFS_COUNT_LOW, 32'hfe);
    bus(1'b1, `STC_OFS_CTRL, 32'h1);
    repeat (16) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `STC_OFS_CTRL, 32'h0);
    rc("high wrapped", `STC_OFS_COUNT_HIGH, 32'h0);
    bus(1'b1, `STC_OFS_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rc("status", `STC_OFS_IRQ_STATUS, 32'h1);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  task automatic t_external();
    bus(1'b1, `STC_OFS_COUNT_LOW, 32'h0);
    bus(1'b1, `STC_OFS_CTRL, 32'h7);
    src.burst(0, 5, 3);
    repeat (10) @(posedge pclk);
    bus(1'b1, `STC_OFS_CTRL, 32'h0);
    rc("pin count", `STC_OFS_COUNT_LOW, 32'h5);
    bus(1'b1, `STC_OFS_COUNT_LOW, 32'h0);
    bus(1'b1, `STC_OFS_CTRL, 32'hb);
    @(posedge pclk);
    chk("osc power", 32'h1, {31'h0, osc_power_en});
    src.burst(1, 3, 8);
    repeat (10) @(posedge pclk);
    bus(1'b1, `STC_OFS_CTRL, 32'h0);
    rc("osc count", `STC_OFS_COUNT_LOW, 32'h3);
  endtask
  task automatic t_unmapped();
    rc("unmapped", 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bytes();
    t_prescale();
    t_wide();
    t_overflow();
    t_external();
    t_unmapped();
    end_of_test();
  end
  // the whole run needs about 800 cycles; this allows over twenty times that
  initial
  begin
    #2000000;
    n_errors++;
    end_of_test();
  end
endmodule
bind stc_timer stc_timer_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .port_c_direction(port_c_direction), .port_c_oe(port_c_oe), .osc_power_en(osc_power_en), .irq(irq));
`default_nettype wire
